/* core/mar_pkg.sv */
// Purpose: Shared constants for the multiply-accumulate operand and accumulator register bank.
// Assumes: Byte-wide special function register bus with page select.
// Notes: Addresses are byte addresses within the page.
package mar_pkg;
	localparam logic [3:0] MAR_PAGE = 4'hF;
	localparam logic [7:0] MAR_ADDR_OPERAND_A_LOW = 8'hAA;
	localparam logic [7:0] MAR_ADDR_OPERAND_A_HIGH = 8'hAB;
	localparam logic [7:0] MAR_ADDR_OPERAND_B_LOW = 8'hAE;
	localparam logic [7:0] MAR_ADDR_OPERAND_B_HIGH = 8'hAF;
	localparam logic [7:0] MAR_ADDR_ACCUM_BYTE_ZERO = 8'hD2;
	localparam logic [7:0] MAR_ADDR_ACCUM_BYTE_ONE = 8'hD3;
	localparam logic [7:0] MAR_ADDR_ACCUM_BYTE_TWO = 8'hD4;
	localparam logic [7:0] MAR_ADDR_ACCUM_BYTE_THREE = 8'hD5;
	localparam logic [7:0] MAR_ADDR_ACCUM_OVERFLOW_BYTE = 8'hD6;
	localparam logic [7:0] MAR_BYTE_RESET = 8'h00;
	localparam int MAR_ACC_BYTES = 5;
	localparam int MAR_ACC_WIDTH = 40;
	localparam logic [7:0] MAR_READ_UNMAPPED = 8'h00;
endpackage

/* core/mar_byte_reg.sv */
// Purpose: One read-write byte register with software and hardware load ports.
// Assumes: Single clock, synchronous active-high reset.
// Notes: A software write takes priority over a hardware load in the same cycle.
module mar_byte_reg (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_sw_we,
	input wire logic [7:0] i_sw_data,
	input wire logic i_hw_we,
	input wire logic [7:0] i_hw_data,
	output logic [7:0] o_value
);
	logic [7:0] value_r;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			value_r <= mar_pkg::MAR_BYTE_RESET;
		end else if (i_sw_we) begin
			value_r <= i_sw_data;
		end else if (i_hw_we) begin
			value_r <= i_hw_data;
		end
	end

	assign o_value = value_r;
endmodule

/* core/mar_regs.sv */
// Purpose: Register bank for operands A and B and the 40-bit accumulator of the
// mult_accum_unit.
// Assumes: Byte-wide special_function_register bus; i_sfr_page qualifies every access.
// Notes: The arithmetic engine sits outside and loads the accumulator through i_acc_load.
//
// Behaviour
// R1 - Operand A is the high byte register above the low byte register.
// R2 - Operand B is the high byte register above the low byte register.
// R3 - The overflow byte holds accumulator bits 39 to 32 and is read-write.
// R4 - Accumulator byte three holds bits 31 to 24 in its own read-write register.
// R5 - Accumulator byte two holds bits 23 to 16 in its own read-write register.
// R6 - Accumulator byte one holds bits 15 to 8 in its own read-write register.
// R7 - All these registers decode on page 0xF, each at a distinct address.
// R8 - Accumulator byte zero holds bits 7 to 0, is read-write and resets to zero.
// R9 - A software write loads its accumulator slice directly and reset clears all bytes.
module mar_regs (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_sfr_page,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_hit,
	input wire logic i_acc_load,
	input wire logic [39:0] i_acc_next,
	output logic [15:0] o_operand_a,
	output logic [15:0] o_operand_b,
	output logic [39:0] o_accum
);
	localparam int NREG = 9;

	logic [7:0] byte_q [NREG];
	logic [NREG-1:0] sel;
	logic [7:0] rdata_r;

	// Index order: a_low, a_high, b_low, b_high, acc0..acc3, overflow.
	function automatic logic [NREG-1:0] decode(input logic [3:0] page, input logic [7:0] addr);
		logic [NREG-1:0] s;
		s = '0;
		if (page != mar_pkg::MAR_PAGE) begin // R7
			s = '0;
		end else if (addr == mar_pkg::MAR_ADDR_OPERAND_A_LOW) begin
			s[0] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_OPERAND_A_HIGH) begin
			s[1] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_OPERAND_B_LOW) begin
			s[2] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_OPERAND_B_HIGH) begin
			s[3] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_ACCUM_BYTE_ZERO) begin
			s[4] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_ACCUM_BYTE_ONE) begin
			s[5] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_ACCUM_BYTE_TWO) begin
			s[6] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_ACCUM_BYTE_THREE) begin
			s[7] = 1'b1;
		end else if (addr == mar_pkg::MAR_ADDR_ACCUM_OVERFLOW_BYTE) begin
			s[8] = 1'b1;
		end
		return s;
	endfunction

	assign sel = decode(i_sfr_page, i_sfr_addr);
	assign o_sfr_hit = |sel;

	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : gen_byte
			// Operand bytes have no hardware load; accumulator bytes take the engine result.
			mar_byte_reg u_byte (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_sw_we(i_sfr_wr & sel[g]), // R9
				.i_sw_data(i_sfr_wdata),
				.i_hw_we((g >= 4) ? i_acc_load : 1'b0),
				.i_hw_data((g >= 4) ? i_acc_next[((g >= 4) ? (g - 4) : 0) * 8 +: 8] : 8'h00),
				.o_value(byte_q[g])
			);
		end
	endgenerate

	assign o_operand_a = {byte_q[1], byte_q[0]}; // R1
	assign o_operand_b = {byte_q[3], byte_q[2]}; // R2
	assign o_accum[7:0] = byte_q[4]; // R8
	assign o_accum[15:8] = byte_q[5]; // R6
	assign o_accum[23:16] = byte_q[6]; // R5
	assign o_accum[31:24] = byte_q[7]; // R4
	assign o_accum[39:32] = byte_q[8]; // R3

	// Read data is registered, so it appears the cycle after the read strobe.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_r <= mar_pkg::MAR_BYTE_RESET;
		end else if (i_sfr_rd) begin
			rdata_r <= mar_pkg::MAR_READ_UNMAPPED;
			for (int k = 0; k < NREG; k++) begin
				if (sel[k]) begin
					rdata_r <= byte_q[k];
				end
			end
		end
	end

	assign o_sfr_rdata = rdata_r;
endmodule

/* dv/mar_regs_properties.sv */
// Purpose: Concurrent checks on the operand and accumulator register bank.
// Assumes: Writes land one edge after the strobe; engine loads are excluded.
// Notes: Attached to every mar_regs instance by bind.
module mar_regs_properties (
	input wire logic i_clk, i_sys_rst, i_sfr_wr, i_acc_load, o_sfr_hit,
	input wire logic [3:0] i_sfr_page,
	input wire logic [7:0] i_sfr_addr, i_sfr_wdata,
	input wire logic [15:0] o_operand_a, o_operand_b,
	input wire logic [39:0] o_accum
);
timeunit 1ns;
timeprecision 1ps;
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_sys_rst);
// An engine load in the same cycle would blur the cause, so only pure writes count.
function automatic logic wa(input logic [7:0] a);
	return i_sfr_wr && !i_acc_load && i_sfr_page == 4'hF && i_sfr_addr == a;
endfunction
chk_a_high_write: assert property (wa(8'hAB) |=> o_operand_a[15:8] == $past(i_sfr_wdata))
	else $error("operand a high byte wrong");
chk_b_low_write: assert property (wa(8'hAE) |=> o_operand_b[7:0] == $past(i_sfr_wdata))
	else $error("operand b low byte wrong");
chk_ovf_write: assert property (wa(8'hD6) |=> o_accum[39:32] == $past(i_sfr_wdata))
	else $error("overflow byte wrong");
chk_acc3_write: assert property (wa(8'hD5) |=> o_accum[31:24] == $past(i_sfr_wdata))
	else $error("accumulator byte three wrong");
chk_acc2_write: assert property (wa(8'hD4) |=> o_accum[23:16] == $past(i_sfr_wdata))
	else $error("accumulator byte two wrong");
chk_acc1_write: assert property (wa(8'hD3) |=> o_accum[15:8] == $past(i_sfr_wdata))
	else $error("accumulator byte one wrong");
chk_page_decode: assert property (i_sfr_page != 4'hF |-> !o_sfr_hit)
	else $error("hit on a foreign page");
chk_acc0_write: assert property (wa(8'hD2) |=> o_accum[7:0] == $past(i_sfr_wdata))
	else $error("accumulator byte zero wrong");
chk_reset_clear: assert property ($past(i_sys_rst) |-> o_accum == 40'h0 && o_operand_a == 16'h0)
	else $error("bytes not cleared by reset");
endmodule
bind mar_regs mar_regs_properties chk_u (.i_clk, .i_sys_rst, .i_sfr_wr, .i_acc_load, .o_sfr_hit,
	.i_sfr_page, .i_sfr_addr, .i_sfr_wdata, .o_operand_a, .o_operand_b, .o_accum);

/* dv/mar_regs_bench.sv */
// Purpose: Register access bench for mar_regs.
// Assumes: Read data is settled one cycle after the strobe.
// Notes: Inputs change on the falling edge only.
module mar_regs_bench;
timeunit 1ns;
timeprecision 1ps;
logic i_clk = 0, i_sys_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_acc_load = 0, o_sfr_hit;
logic [3:0] i_sfr_page = 4'hF;
logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
logic [15:0] o_operand_a, o_operand_b;
logic [39:0] i_acc_next = 40'h0, o_accum;
int num_errors = 0, cmp_count = 0;
logic [7:0] ad [9] = '{8'hAA, 8'hAB, 8'hAE, 8'hAF, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6};
always #4 i_clk = ~i_clk;
mar_regs dut_u (.i_clk, .i_sys_rst, .i_sfr_page, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
	.i_sfr_wdata, .o_sfr_rdata, .o_sfr_hit, .i_acc_load, .i_acc_next, .o_operand_a,
	.o_operand_b, .o_accum);
task chk(input logic [39:0] g, e);
	cmp_count++;
	if (g !== e) begin
		num_errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task wr(input logic [3:0] p, input logic [7:0] a, d);
	@(negedge i_clk);
	{i_sfr_page, i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {p, a, d, 1'b1};
	@(negedge i_clk);
	i_sfr_wr = 1'b0;
endtask
task rd(input logic [3:0] p, input logic [7:0] a, e);
	@(negedge i_clk);
	{i_sfr_page, i_sfr_addr, i_sfr_rd} = {p, a, 1'b1};
	@(negedge i_clk);
	i_sfr_rd = 1'b0;
	chk(o_sfr_rdata, e);
endtask
task finish_test;
	$display("errors=%0d compares=%0d", num_errors, cmp_count);
	if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
initial begin
	repeat (12) @(negedge i_clk);
	i_sys_rst = 1'b0;
	foreach (ad[k]) rd(4'hF, ad[k], 8'h00);
	foreach (ad[k]) wr(4'hF, ad[k], ad[k] ^ 8'h3C);
	foreach (ad[k]) rd(4'hF, ad[k], ad[k] ^ 8'h3C);
	chk(o_sfr_hit, 1'b1);
	chk(o_operand_a, 16'h9796);
	chk(o_operand_b, 16'h9392);
	chk(o_accum, 40'hEAE9E8EFEE);
	wr(4'hE, 8'hAA, 8'h11);
	rd(4'hE, 8'hAA, 8'h00);
	chk(o_sfr_hit, 1'b0);
	rd(4'hF, 8'hD7, 8'h00);
	chk(o_sfr_hit, 1'b0);
	chk(o_operand_a, 16'h9796);
	// A software write beats the engine load for its own byte only.
	@(negedge i_clk);
	{i_acc_next, i_acc_load, i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {40'h0123456789, 1'b1, 8'hD3, 8'h55, 1'b1};
	@(negedge i_clk);
	{i_acc_load, i_sfr_wr} = 2'b00;
	chk(o_accum, 40'h0123455589);
	i_sys_rst = 1'b1;
	repeat (2) @(negedge i_clk);
	i_sys_rst = 1'b0;
	chk(o_accum, 40'h0);
	chk(o_operand_b, 16'h0);
	finish_test;
end
initial begin
	#20000;
	num_errors++;
	finish_test;
end
endmodule
